//--- hdl/preamble_pkg.sv
// Purpose: Shared constants and carriers for the receive preamble detector.
// Assumes: One bit of demodulated data per bit strobe on the modem clock.
// Notes:   Detection thresholds are counted in received bits.
package preamble_pkg;

  localparam int          THRESH_W            = 7;
  localparam int          FIFO_W              = 8;
  localparam int          FIFO_DEPTH          = 8;
  localparam logic [6:0]  THRESH_DEFAULT      = 7'h14;
  localparam logic [6:0]  THRESH_DIVERSITY    = 7'h18;
  localparam logic [6:0]  LEGACY_MIN_BITS     = 7'h14;
  localparam logic [3:0]  ARRIVAL_BITS        = 4'h8;
  localparam logic [4:0]  ARRIVAL_AFC_BITS    = 5'h10;
  localparam logic [2:0]  BCR_LOCK_EDGES      = 3'h4;
  localparam logic [4:0]  NSTD_LEN_BITS       = 5'h10;
  localparam logic [7:0]  PATTERN_DEFAULT     = 8'haa;
  localparam logic [7:0]  SYNC_SEARCH_BITS    = 8'hff;

  typedef enum logic [1:0] {
    DET_STANDARD,
    DET_NONSTANDARD,
    DET_ARRIVAL
  } det_mode_type;

  typedef struct packed {
    det_mode_type  mode;
    logic [6:0]    thresh;
    logic          afc_en;
    logic          diversity_en;
    logic [7:0]    pattern;
    logic          jump_collision;
  } preamble_cfg_type;

  typedef struct packed {
    logic        valid;
    logic [7:0]  data;
  } byte_beat_type;

endpackage : preamble_pkg

//--- hdl/bit_fifo.sv
// Purpose: Small synchronous FIFO carrying assembled received bytes.
// Assumes: Single clock; reader may stall to apply back-pressure.
// Notes:   Full and empty come from an occupancy count.
`timescale 1ns/1ps
module bit_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_in,
  input  wire logic             rst_b_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  assign in_ready_out  = (count_r != (AW+1)'(DEPTH));
  assign out_valid_out = (count_r != '0);
  assign out_data_out  = mem[rd_ptr_r];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  always_ff @(posedge clk_in)
  begin
    if (push)
    begin
      mem[wr_ptr_r] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop)
      begin
        count_r <= count_r + 1'b1;
      end
      else if (pop && !push)
      begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule : bit_fifo

//--- hdl/rx_preamble_detector.sv
// Purpose: Qualifies a received preamble, then gates bytes toward sync search.
// Assumes: bit_strobe_in marks each recovered bit; pins pass a 2-FF sync.
// Notes:   Three detectors: standard count, repeating pattern, RSSI jump.
`timescale 1ns/1ps

// Contract
// - Arrival detector qualifies after one byte
// - With correction, arrival qualifies within two bytes
// - Legacy counting detector stays selectable
// - Arrival result drives hop and sense triggers
// - Arrival built on jump; flag collision reconfigure
// - Qualify preamble before receiving sync and payload
// - Alternating bit count reaching 7-bit threshold qualifies
// - Any detection proceeds to sync search
// - Twenty bit threshold, 24 with diversity
// - Threshold only standard; pattern settings nonstandard
// - Thresholds already include gain and clock settling
// - Standard type means alternating bits
// - Zero threshold needs three-byte sync match
// - Bit clock locks within four transitions
module rx_preamble_detector (
  input  wire logic                          clk_in,
  input  wire logic                          rst_b_in,
  input  wire logic                          rx_enter_in,
  input  wire logic                          bit_strobe_in,
  input  wire logic                          rx_bit_in,
  input  wire logic                          rssi_jump_in,
  input  wire preamble_pkg::preamble_cfg_type cfg_in,
  input  wire logic                          use_default_thresh_in,
  input  wire logic                          byte_ready_in,
  output logic                               byte_valid_out,
  output logic [7:0]                         byte_data_out,
  output logic                               preamble_det_out,
  output logic                               arrival_det_out,
  output logic                               hop_trigger_out,
  output logic                               sense_wake_out,
  output logic                               sync_search_out,
  output logic                               sync_3byte_req_out,
  output logic                               jump_reconfig_out,
  output logic                               bcr_locked_out,
  output logic                               cfg_error_out
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SEARCH,
    ST_SYNC
  } phase_type;

  typedef struct packed {
    logic [1:0]  bit_sync;
    logic [1:0]  stb_sync;
    logic [1:0]  jump_sync;
    phase_type   phase;
    logic        last_bit;
    logic [6:0]  alt_count;
    logic [4:0]  arr_count;
    logic        jump_seen;
    logic [7:0]  shift;
    logic [2:0]  bit_idx;
    logic [4:0]  pat_count;
    logic [2:0]  edge_count;
    logic        det;
    logic        arr_det;
    logic        hop;
    logic        sense;
    logic        jump_reconfig;
    logic        bcr_locked;
    logic        cfg_error;
    logic        sync_3byte;
    logic        sync_search;
    logic        byte_valid;
    logic [7:0]  byte_data;
  } state_type;

  state_type   st_r;
  state_type   st_nxt;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [7:0]  fifo_out_data;
  logic [6:0]  thresh_eff;
  logic [4:0]  arr_target;
  logic        bit_now;
  logic        stb_now;
  logic        jump_now;
  logic        push_byte;
  logic        pop_byte;

  assign bit_now  = st_r.bit_sync[1];
  assign stb_now  = st_r.stb_sync[1];
  assign jump_now = st_r.jump_sync[1];

  // Default thresholds already carry gain and clock settling margin
  always_comb
  begin
    if (use_default_thresh_in)
    begin
      thresh_eff = cfg_in.diversity_en ? preamble_pkg::THRESH_DIVERSITY
                                       : preamble_pkg::THRESH_DEFAULT;
    end
    else
    begin
      thresh_eff = cfg_in.thresh;
    end
    arr_target = cfg_in.afc_en ? preamble_pkg::ARRIVAL_AFC_BITS
                               : {1'b0, preamble_pkg::ARRIVAL_BITS};
  end

  always_comb
  begin
    st_nxt            = st_r;
    push_byte         = 1'b0;
    st_nxt.bit_sync   = {st_r.bit_sync[0], rx_bit_in};
    st_nxt.stb_sync   = {st_r.stb_sync[0], bit_strobe_in};
    st_nxt.jump_sync  = {st_r.jump_sync[0], rssi_jump_in};
    st_nxt.hop        = 1'b0;
    st_nxt.sense      = 1'b0;
    // The shown byte is a copy of the FIFO head; a taken byte is hidden
    // for one cycle so the copy never offers the same byte twice
    pop_byte          = byte_ready_in && st_r.byte_valid;
    st_nxt.byte_valid = fifo_out_valid && !pop_byte;
    st_nxt.byte_data  = fifo_out_data;
    st_nxt.cfg_error  = (cfg_in.mode == preamble_pkg::DET_NONSTANDARD)
                        && cfg_in.afc_en;
    st_nxt.sync_3byte = (cfg_in.mode == preamble_pkg::DET_NONSTANDARD)
                        || (thresh_eff == 7'h00);
    if (rx_enter_in)
    begin
      // Judged on the live setting: the registered flag may still be stale
      st_nxt.phase         = st_nxt.cfg_error ? ST_IDLE
                                              : ST_SEARCH;
      st_nxt.det           = 1'b0;
      st_nxt.arr_det       = 1'b0;
      st_nxt.jump_reconfig = 1'b0;
      st_nxt.alt_count     = '0;
      st_nxt.arr_count     = '0;
      st_nxt.pat_count     = '0;
      st_nxt.jump_seen     = 1'b0;
      st_nxt.bit_idx       = '0;
      st_nxt.edge_count    = '0;
      st_nxt.bcr_locked    = 1'b0;
    end
    else if (stb_now && st_r.phase != ST_IDLE)
    begin
      st_nxt.last_bit = bit_now;
      st_nxt.shift    = {st_r.shift[6:0], bit_now};
      st_nxt.bit_idx  = st_r.bit_idx + 3'h1;
      if (bit_now != st_r.last_bit
          && st_r.edge_count != preamble_pkg::BCR_LOCK_EDGES)
      begin
        st_nxt.edge_count = st_r.edge_count + 3'h1;
      end
      st_nxt.bcr_locked = (st_nxt.edge_count
                           == preamble_pkg::BCR_LOCK_EDGES);
      if (st_r.phase == ST_SEARCH)
      begin
        // Legacy detector: consecutive alternating bits
        // The first bit of a run counts as one; a repeated bit starts a
        // new run of one, so a run of N alternating bits counts N
        if (st_r.alt_count == 7'h00 || bit_now != st_r.last_bit)
        begin
          if (st_r.alt_count != 7'h7f)
          begin
            st_nxt.alt_count = st_r.alt_count + 7'h1;
          end
        end
        else
        begin
          st_nxt.alt_count = 7'h01;
        end
        // Arrival detector counts bits after an RSSI jump
        if (jump_now)
        begin
          st_nxt.jump_seen = 1'b1;
        end
        // Saturates so a long standard search cannot wrap it
        if ((st_r.jump_seen || jump_now) && st_r.arr_count != 5'h1f)
        begin
          st_nxt.arr_count = st_r.arr_count + 5'h1;
        end
        // Non-standard: repeating pattern match, threshold unused
        if ({st_r.shift[6:0], bit_now} == cfg_in.pattern)
        begin
          if (st_r.pat_count != 5'h1f)
          begin
            st_nxt.pat_count = st_r.pat_count + 5'h1;
          end
        end
        unique case (cfg_in.mode)
          preamble_pkg::DET_STANDARD:
          begin
            st_nxt.det = st_nxt.alt_count >= thresh_eff
                         && st_nxt.alt_count != 7'h00;
          end
          preamble_pkg::DET_NONSTANDARD:
          begin
            st_nxt.det = st_nxt.pat_count != 5'h00;
          end
          preamble_pkg::DET_ARRIVAL:
          begin
            st_nxt.det = st_nxt.arr_count >= arr_target;
          end
          default:
          begin
            st_nxt.det = 1'b0;
          end
        endcase
        if (st_nxt.det)
        begin
          // Noise can qualify too; we still commit to the sync search
          st_nxt.phase   = ST_SYNC;
          st_nxt.bit_idx = '0;
          if (cfg_in.mode == preamble_pkg::DET_ARRIVAL)
          begin
            st_nxt.arr_det       = 1'b1;
            st_nxt.hop           = 1'b1;
            st_nxt.sense         = 1'b1;
            st_nxt.jump_reconfig = cfg_in.jump_collision;
          end
        end
      end
      else if (st_r.bit_idx == 3'h7)
      begin
        // Bytes only flow once qualified; a full FIFO drops the byte
        push_byte = 1'b1;
      end
    end
    // Registered so the port comes from a flop; FIFO room lags one cycle
    st_nxt.sync_search = (st_nxt.phase == ST_SYNC)
                         && fifo_in_ready;
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      st_r       <= '0;
      st_r.phase <= ST_IDLE;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  bit_fifo #(
    .WIDTH (preamble_pkg::FIFO_W),
    .DEPTH (preamble_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (clk_in),
    .rst_b_in      (rst_b_in),
    .in_valid_in   (push_byte),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    ({st_r.shift[6:0], bit_now}),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (pop_byte),
    .out_data_out  (fifo_out_data)
  );

  assign byte_valid_out     = st_r.byte_valid;
  assign byte_data_out      = st_r.byte_data;
  assign preamble_det_out   = st_r.det;
  assign arrival_det_out    = st_r.arr_det;
  assign hop_trigger_out    = st_r.hop;
  assign sense_wake_out     = st_r.sense;
  assign sync_search_out    = st_r.sync_search;
  assign sync_3byte_req_out = st_r.sync_3byte;
  assign jump_reconfig_out  = st_r.jump_reconfig;
  assign bcr_locked_out     = st_r.bcr_locked;
  assign cfg_error_out      = st_r.cfg_error;

endmodule : rx_preamble_detector

//--- tb/rx_preamble_detector_sva.sv
// Purpose: Port-level checks for the receive preamble detector.
// Assumes: One clock domain, reset asynchronous and active low.
// Notes:   Detection latency is left to the bench; these tie order, 0-2 cycle windows and byte hold.
`timescale 1ns/1ps
module rx_preamble_detector_sva (
  input wire logic                           clk_in,
  input wire logic                           rst_b_in,
  input wire logic                           rx_enter_in,
  input wire preamble_pkg::preamble_cfg_type cfg_in,
  input wire logic                           byte_ready_in,
  input wire logic                           byte_valid_out,
  input wire logic [7:0]                     byte_data_out,
  input wire logic                           preamble_det_out,
  input wire logic                           arrival_det_out,
  input wire logic                           hop_trigger_out,
  input wire logic                           sense_wake_out,
  input wire logic                           sync_search_out,
  input wire logic                           cfg_error_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  sequence s_arrive;
    $rose(arrival_det_out);
  endsequence
  sequence s_pulse;
    hop_trigger_out && sense_wake_out ##1 !hop_trigger_out && !sense_wake_out;
  endsequence
  AST_HOP_ON_ARRIVAL: assert property (s_arrive |-> ##[0:1] s_pulse)
    else $error("hop or wake pulse missing at arrival");
  AST_ARRIVAL_MODE: assert property ($rose(arrival_det_out) |->
    cfg_in.mode == preamble_pkg::DET_ARRIVAL)
    else $error("arrival flag outside arrival mode");
  AST_DET_STICKY: assert property (preamble_det_out && !rx_enter_in
    |=> preamble_det_out)
    else $error("detect flag dropped without restart");
  AST_DET_CLEAR: assert property (rx_enter_in |=>
    !preamble_det_out && !arrival_det_out)
    else $error("detect flags survive restart");
  AST_ERR_BLOCKS: assert property (cfg_error_out |-> !preamble_det_out)
    else $error("detection under unsupported setting");
  AST_BYTE_AFTER_DET: assert property ($rose(byte_valid_out) |->
    preamble_det_out)
    else $error("byte before qualification");
  AST_SEARCH_AFTER_DET: assert property ($rose(preamble_det_out) |->
    ##[0:2] sync_search_out)
    else $error("no sync search after detection");
  AST_SEARCH_NEEDS_DET: assert property (!preamble_det_out |->
    !sync_search_out)
    else $error("sync search without detection");
  AST_BYTE_HOLD: assert property (byte_valid_out && !byte_ready_in |=>
    byte_valid_out && $stable(byte_data_out))
    else $error("byte changed while stalled");
endmodule : rx_preamble_detector_sva

bind rx_preamble_detector rx_preamble_detector_sva sva (
  .clk_in, .rst_b_in, .rx_enter_in, .cfg_in, .byte_ready_in,
  .byte_valid_out, .byte_data_out, .preamble_det_out, .arrival_det_out,
  .hop_trigger_out, .sense_wake_out, .sync_search_out, .cfg_error_out);

//--- tb/tx_preamble_model.sv
// Purpose: Remote transmitter: alternating preamble, then payload bytes.
// Assumes: One bit every four clocks, first preamble bit is one.
// Notes:   Data line toggles when idle so a stale level is never trusted.
`timescale 1ns/1ps
module tx_preamble_model (
  input  wire logic        clk_in,
  input  wire logic        start_in,
  input  wire logic [6:0]  pre_len_in,
  input  wire logic [63:0] pay_in,
  input  wire logic [3:0]  pay_bytes_in,
  output logic             strobe_out,
  output logic             bit_out,
  output logic             jump_out,
  output logic             busy_out
);
  int n = 0;
  int ph = 0;
  initial
  begin
    {strobe_out, bit_out, jump_out, busy_out} = 4'h0;
  end
  // Acts on the rising edge so it never races the bench's falling-edge start
  always @(posedge clk_in)
  begin
    if (!busy_out)
    begin
      strobe_out <= 1'b0;
      bit_out    <= !bit_out;
      jump_out   <= start_in;
      busy_out   <= start_in;
      n          <= 0;
      ph         <= 0;
    end
    else if (n == int'(pre_len_in) + 8 * int'(pay_bytes_in))
    begin
      strobe_out <= 1'b0;
      busy_out   <= 1'b0;
    end
    else
    begin
      ph         <= ph + 1;
      strobe_out <= (ph % 4 == 3);
      if (ph % 4 == 3)
      begin
        bit_out <= (n < pre_len_in) ? !n[0] : pay_in[63 - (n - pre_len_in)];
        n       <= n + 1;
      end
    end
  end
endmodule : tx_preamble_model

//--- tb/rx_preamble_detector_tb.sv
// Purpose: Self-checking bench for the receive preamble detector.
// Assumes: Bench-driven inputs change on the falling edge; the transmitter model drives strobe, bit and jump on the rising edge.
// Notes:   Thresholds are sent exactly, one bit short and then in full.
`timescale 1ns/1ps
module rx_preamble_detector_tb;
  logic                           clk_in;
  logic                           rst_b_in;
  logic                           rx_enter_in;
  logic                           use_def;
  logic                           ready;
  logic                           start;
  logic [6:0]                     pre_len;
  logic [63:0]                    pay;
  logic [3:0]                     nbytes;
  logic                           strobe, rx_bit, jump, busy;
  logic                           bvalid, det, arr, hop, search, err;
  logic [7:0]                     bdata;
  logic                           b3, lock, jrc;
  preamble_pkg::preamble_cfg_type cfg;
  int                             failures, cmp_count, hops;

  rx_preamble_detector dut (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .rx_enter_in(rx_enter_in), .bit_strobe_in(strobe), .rx_bit_in(rx_bit),
    .rssi_jump_in(jump), .cfg_in(cfg), .use_default_thresh_in(use_def),
    .byte_ready_in(ready), .byte_valid_out(bvalid), .byte_data_out(bdata),
    .preamble_det_out(det), .arrival_det_out(arr), .hop_trigger_out(hop),
    .sense_wake_out(), .sync_search_out(search), .sync_3byte_req_out(b3),
    .jump_reconfig_out(jrc), .bcr_locked_out(lock), .cfg_error_out(err));
  tx_preamble_model tx (.clk_in(clk_in), .start_in(start),
    .pre_len_in(pre_len), .pay_in(pay), .pay_bytes_in(nbytes),
    .strobe_out(strobe), .bit_out(rx_bit), .jump_out(jump), .busy_out(busy));

  initial
  begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  always @(negedge clk_in)
    if (hop === 1'b1)
      hops++;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report

  task automatic frame(input preamble_pkg::det_mode_type m, input logic afc,
                       input logic div, input int bits, input int nb);
    int t;
    @(negedge clk_in);
    cfg.mode = m;
    cfg.afc_en = afc;
    cfg.diversity_en = div;
    rx_enter_in = 1'b1;
    @(negedge clk_in);
    rx_enter_in = 1'b0;
    pre_len = 7'(bits);
    nbytes = 4'(nb);
    start = 1'b1;
    repeat (2) @(negedge clk_in);
    check(8'(det), 8'h00);
    start = 1'b0;
    for (t = 0; busy && t < 600; t++)
      @(negedge clk_in);
    if (busy)
    begin
      failures++;
      final_report();
    end
    repeat (8) @(negedge clk_in);
  endtask : frame

  task automatic drain(input int n);
    int t;
    for (int k = 0; k < n; k++)
    begin
      for (t = 0; !bvalid && t < 50; t++)
        @(negedge clk_in);
      if (!bvalid)
      begin
        failures++;
        final_report();
      end
      check(bdata, pay[63-8*k -: 8]);
      ready = 1'b1;
      @(negedge clk_in);
      ready = 1'b0;
      @(negedge clk_in);
    end
    repeat (4) @(negedge clk_in);
    check(8'(bvalid), 8'h00);
  endtask : drain

  // Default threshold, plain and with diversity: one bit short, then exact
  task automatic std_default;
    int lim;
    use_def = 1'b1;
    for (int d = 0; d < 2; d++)
    begin
      lim = (d == 1) ? 24 : 20;
      frame(preamble_pkg::DET_STANDARD, 1'b0, d[0], lim - 1, 0);
      check(8'(det), 8'h00);
      frame(preamble_pkg::DET_STANDARD, 1'b0, d[0], lim, 1);
      check(8'(det), 8'h01);
      check(8'(lock), 8'h01);
      check(8'(b3), 8'h00);
      drain(1);
    end
  endtask : std_default

  // Programmed threshold; stalled reader fills the buffer until it refuses
  task automatic fifo_fill;
    use_def = 1'b0;
    cfg.thresh = 7'h05;
    frame(preamble_pkg::DET_STANDARD, 1'b0, 1'b0, 4, 0);
    check(8'(det), 8'h00);
    frame(preamble_pkg::DET_STANDARD, 1'b0, 1'b0, 5, 8);
    check(8'(det), 8'h01);
    check(8'(search), 8'h00);
    drain(8);
    check(8'(search), 8'h01);
  endtask : fifo_fill

  task automatic nonstandard;
    frame(preamble_pkg::DET_NONSTANDARD, 1'b1, 1'b0, 16, 0);
    check({7'h00, err}, 8'h01);
    check(8'(det), 8'h00);
    frame(preamble_pkg::DET_NONSTANDARD, 1'b0, 1'b0, 16, 0);
    check(8'(err), 8'h00);
    check(8'(det), 8'h01);
    check(8'(b3), 8'h01);
  endtask : nonstandard

  task automatic arrival;
    hops = 0;
    cfg.jump_collision = 1'b1;
    for (int a = 0; a < 2; a++)
    begin
      frame(preamble_pkg::DET_ARRIVAL, a[0], 1'b0, 8 * (a + 1) - 1, 0);
      check(8'(arr), 8'h00);
      frame(preamble_pkg::DET_ARRIVAL, a[0], 1'b0, 8 * (a + 1), 0);
      check(8'(arr), 8'h01);
      check(8'(hops), 8'(a + 1));
      check(8'(jrc), 8'h01);
    end
  endtask : arrival

  initial
  begin
    cfg = '0;
    cfg.pattern = preamble_pkg::PATTERN_DEFAULT;
    {rst_b_in, rx_enter_in, use_def, ready, start} = 5'h00;
    pre_len = 7'h00;
    nbytes = 4'h0;
    pay = 64'ha53c_0f96_e1d2_7b48;
    failures = 0;
    cmp_count = 0;
    repeat (16) @(negedge clk_in);
    rst_b_in = 1'b1;
    std_default();
    fifo_fill();
    nonstandard();
    arrival();
    final_report();
  end
endmodule : rx_preamble_detector_tb
